// ### hdl/nirm_regs.sv
`timescale 1ns/100ps
// Node identity, bus options tail and configuration ROM mapping registers.
module nirm_regs (
  // Clock and reset
  input  wire logic                    core_clk,
  input  wire logic                    resetn,
  // Software reset, leaves every register untouched
  input  wire logic                    soft_reset,
  // Register port
  input  wire nirm_pkg::nirm_bus_t     bus,
  output nirm_pkg::nirm_bus_t          unused_bus_echo_n,
  output logic [31:0]                  rdata,
  // Serial EEPROM loader results
  input  wire logic                    ee_upper_load,
  input  wire logic                    ee_lower_load,
  input  wire logic [31:0]             ee_data,
  // Lock status
  output logic                         uid_upper_locked,
  output logic                         uid_lower_locked,
  // Configuration ROM read mapping
  input  wire nirm_pkg::nirm_rom_req_t rom_req,
  output nirm_pkg::nirm_rom_map_t      rom_map
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [1:0]  gen_q;
  logic [1:0]  gen_d;
  logic [3:0]  maxrec_q;
  logic [3:0]  maxrec_d;
  logic [21:0] base_q;
  logic [21:0] base_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic        up_lk_q;
  logic        lo_lk_q;
  logic        map_vld_q;
  logic        map_vld_d;
  logic [31:0] map_addr_q;
  logic [31:0] map_addr_d;
  logic [31:0] uid_upper;
  logic [31:0] uid_lower;
  logic        up_lk;
  logic        lo_lk;
  logic        wr_upper;
  logic        wr_lower;
  logic        in_window;

  // Write strobes for the ID quadlets; the lock inside drops late writes.
  assign wr_upper = bus.wr && (bus.addr == nirm_pkg::NIRM_OFS_UID_UPPER);
  assign wr_lower = bus.wr && (bus.addr == nirm_pkg::NIRM_OFS_UID_LOWER);

  // ----------------------------------------------------------------
  // Unique-ID quadlets
  // ----------------------------------------------------------------
  nirm_uid_reg u_uid_upper (
    .core_clk (core_clk),
    .resetn   (resetn),
    .ee_load  (ee_upper_load),
    .ee_data  (ee_data),
    .sw_load  (wr_upper),
    .sw_data  (bus.wdata),
    .value    (uid_upper),
    .locked   (up_lk)
  );

  nirm_uid_reg u_uid_lower (
    .core_clk (core_clk),
    .resetn   (resetn),
    .ee_load  (ee_lower_load),
    .ee_data  (ee_data),
    .sw_load  (wr_lower),
    .sw_data  (bus.wdata),
    .value    (uid_lower),
    .locked   (lo_lk)
  );

  // ----------------------------------------------------------------
  // Writable fields
  // ----------------------------------------------------------------
  // Generation count is software-owned; reserved bits have no storage.
  always_comb begin
    gen_d    = gen_q;
    maxrec_d = maxrec_q;
    base_d   = base_q;
    if (bus.wr && bus.addr == nirm_pkg::NIRM_OFS_BUS_CAP) begin
      gen_d    = bus.wdata[nirm_pkg::NIRM_GEN_LSB +: 2];
      maxrec_d = bus.wdata[nirm_pkg::NIRM_MAXREC_LSB +: 4];
    end
    if (bus.wr && bus.addr == nirm_pkg::NIRM_OFS_ROM_BASE) begin
      base_d = bus.wdata[31:nirm_pkg::NIRM_BASE_LSB];
    end
  end

  // Soft reset is ignored here on purpose: only the hardware reset restores it.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      gen_q    <= 2'h0;
      maxrec_q <= nirm_pkg::NIRM_MAXREC_RST;
      base_q   <= nirm_pkg::NIRM_BASE_RST;
    end else begin
      gen_q    <= gen_d;
      maxrec_q <= maxrec_d;
      base_q   <= base_d;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Unmapped offsets read zero so software never sees stale data.
  always_comb begin
    rdata_d = 32'h00000000;
    if (bus.rd) begin
      case (bus.addr)
        nirm_pkg::NIRM_OFS_BUS_CAP: begin
          rdata_d[nirm_pkg::NIRM_MAXREC_LSB +: 4] = maxrec_q;
          rdata_d[nirm_pkg::NIRM_GEN_LSB +: 2]    = gen_q;
          rdata_d[2:0] = nirm_pkg::NIRM_LINK_SPEED;
        end // Bits 11-8 and 5-3 stay zero.
        nirm_pkg::NIRM_OFS_UID_UPPER: rdata_d = uid_upper;
        nirm_pkg::NIRM_OFS_UID_LOWER: rdata_d = uid_lower;
        nirm_pkg::NIRM_OFS_ROM_BASE: begin
          rdata_d[31:nirm_pkg::NIRM_BASE_LSB] = base_q;
        end
        default: rdata_d = 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Configuration ROM address mapping
  // ----------------------------------------------------------------
  assign in_window = (rom_req.offset >= nirm_pkg::NIRM_ROM_WIN_LO) &&
                     (rom_req.offset <= nirm_pkg::NIRM_ROM_WIN_HI);

  // The base is 1 KiB aligned, so the add never carries into the base bits.
  always_comb begin
    map_vld_d  = rom_req.valid && in_window;
    map_addr_d = map_addr_q;
    if (map_vld_d) begin
      map_addr_d = {base_q, 10'h000} + {22'h000000, rom_req.offset[9:0]};
    end
  end

  // Result is registered so the memory side sees a clean request.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      rdata_q    <= 32'h00000000;
      up_lk_q    <= 1'b0;
      lo_lk_q    <= 1'b0;
      map_vld_q  <= 1'b0;
      map_addr_q <= 32'h00000000;
    end else begin
      rdata_q    <= rdata_d;
      up_lk_q    <= up_lk;
      lo_lk_q    <= lo_lk;
      map_vld_q  <= map_vld_d;
      map_addr_q <= map_addr_d;
    end
  end

  assign rdata             = rdata_q;
  assign uid_upper_locked  = up_lk_q;
  assign uid_lower_locked  = lo_lk_q;
  assign rom_map.valid     = map_vld_q;
  assign rom_map.addr      = map_addr_q;
  assign unused_bus_echo_n = '0;

endmodule // nirm_regs

// ### hdl/nirm_pkg.sv
package nirm_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] NIRM_OFS_BUS_CAP   = 8'h20;
  localparam logic [7:0] NIRM_OFS_UID_UPPER = 8'h24;
  localparam logic [7:0] NIRM_OFS_UID_LOWER = 8'h28;
  localparam logic [7:0] NIRM_OFS_ROM_BASE  = 8'h34;

  // ----------------------------------------------------------------
  // Field layout and reset values
  // ----------------------------------------------------------------
  localparam int          NIRM_GEN_LSB      = 6;
  localparam int          NIRM_MAXREC_LSB   = 12;
  localparam logic [2:0]  NIRM_LINK_SPEED   = 3'h2;
  localparam logic [3:0]  NIRM_MAXREC_RST   = 4'hA;
  localparam logic [31:0] NIRM_UID_RST      = 32'h00000000;
  localparam logic [21:0] NIRM_BASE_RST     = 22'h000000;
  localparam int          NIRM_BASE_LSB     = 10;
  localparam logic [47:0] NIRM_ROM_WIN_LO   = 48'hFFFFF0000400;
  localparam logic [47:0] NIRM_ROM_WIN_HI   = 48'hFFFFF00007FF;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } nirm_bus_t;

  typedef struct packed {
    logic        valid;
    logic [47:0] offset;
  } nirm_rom_req_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
  } nirm_rom_map_t;

endpackage

// ### hdl/nirm_uid_reg.sv
`timescale 1ns/100ps
// One unique-ID quadlet with its lock flag.
module nirm_uid_reg (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        resetn,
  // Load sources
  input  wire logic        ee_load,
  input  wire logic [31:0] ee_data,
  input  wire logic        sw_load,
  input  wire logic [31:0] sw_data,
  // State
  output logic [31:0]      value,
  output logic             locked
);

  logic [31:0] val_q;
  logic [31:0] val_d;
  logic        lock_q;
  logic        lock_d;

  // The EEPROM wins a same-cycle tie since it reflects the board's true ID.
  always_comb begin
    val_d  = val_q;
    lock_d = lock_q;
    if (!lock_q) begin
      if (ee_load) begin
        val_d  = ee_data;
        lock_d = 1'b1;
      end else if (sw_load) begin
        val_d  = sw_data;
        lock_d = 1'b1;
      end
    end
  end

  // Reset gives the invalid all-zero identifier.
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      val_q  <= nirm_pkg::NIRM_UID_RST;
      lock_q <= 1'b0;
    end else begin
      val_q  <= val_d;
      lock_q <= lock_d;
    end
  end

  assign value  = val_q;
  assign locked = lock_q;

endmodule // nirm_uid_reg

// ### tb/nirm_regs_checker.sv
`timescale 1ns/100ps
// Watches the register port, the lock flags and the ROM map.
module nirm_regs_checker (
  input wire logic                    core_clk,
  input wire logic                    resetn,
  input wire nirm_pkg::nirm_bus_t     bus,
  input wire logic [31:0]             rdata,
  input wire logic                    ee_upper_load,
  input wire logic                    uid_upper_locked,
  input wire logic                    uid_lower_locked,
  input wire nirm_pkg::nirm_rom_req_t rom_req,
  input wire nirm_pkg::nirm_rom_map_t rom_map
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  logic hit;
  // A request counts only inside the ROM window.
  assign hit = rom_req.valid && rom_req.offset >= nirm_pkg::NIRM_ROM_WIN_LO
    && rom_req.offset <= nirm_pkg::NIRM_ROM_WIN_HI;
  property p_spd; $past(bus.rd && bus.addr == 8'h20) |-> rdata[2:0] == 3'h2; endproperty
  a_spd: assert property (p_spd) else $error("bad speed code");
  property p_rsv;
    $past(bus.rd && bus.addr == 8'h20) |-> {rdata[11:8], rdata[5:3]} == 7'h00;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits set");
  property p_base; $past(bus.rd && bus.addr == 8'h34) |-> rdata[9:0] == 10'h000; endproperty
  a_base: assert property (p_base) else $error("base low bits set");
  property p_map; hit |=> rom_map.valid && rom_map.addr[9:0] == $past(rom_req.offset[9:0]);
  endproperty
  a_map: assert property (p_map) else $error("bad mapped address");
  property p_miss; !hit |=> !rom_map.valid; endproperty
  a_miss: assert property (p_miss) else $error("map outside window");
  property p_lock; ee_upper_load |-> ##[1:2] uid_upper_locked; endproperty
  a_lock: assert property (p_lock) else $error("load did not lock");
  property p_hold_u; uid_upper_locked |=> uid_upper_locked; endproperty
  a_hold_u: assert property (p_hold_u) else $error("upper lock lost");
  property p_hold_l; uid_lower_locked |=> uid_lower_locked; endproperty
  a_hold_l: assert property (p_hold_l) else $error("lower lock lost");
  c_map: cover property (rom_map.valid);
  c_lock: cover property (uid_upper_locked && uid_lower_locked);
  c_ro: cover property (uid_upper_locked && bus.wr && bus.addr == 8'h24);
endmodule // nirm_regs_checker
bind nirm_regs nirm_regs_checker u_chk (.core_clk, .resetn, .bus, .rdata, .ee_upper_load,
  .uid_upper_locked, .uid_lower_locked, .rom_req, .rom_map);

// ### tb/nirm_rom_node.sv
`timescale 1ns/100ps
// Remote node issuing quadlet reads; idle offset is inverted so no stale copy shows.
module nirm_rom_node (
  input wire logic                core_clk,
  output nirm_pkg::nirm_rom_req_t rom_req
);
  initial rom_req = '0;
  task automatic read_quad(input logic [47:0] ofs);
    @(posedge core_clk);
    rom_req <= {1'b1, ofs};
    @(posedge core_clk);
    rom_req <= {1'b0, ~ofs};
  endtask
endmodule // nirm_rom_node

// ### tb/nirm_regs_tb.sv
`timescale 1ns/100ps
module nirm_regs_tb;
  logic                    core_clk = 1'b0;
  logic                    resetn = 1'b0;
  logic                    soft_reset = 1'b0;
  logic                    ee_upper_load = 1'b0;
  logic                    ee_lower_load = 1'b0;
  logic [31:0]             ee_data = 32'h0;
  nirm_pkg::nirm_bus_t     bus = '0;
  logic [31:0]             rdata;
  logic                    up_lk;
  logic                    lo_lk;
  nirm_pkg::nirm_rom_req_t rom_req;
  nirm_pkg::nirm_rom_map_t rom_map;
  int                      bad_count = 0;
  int                      n_tests = 0;
  initial forever #12.5 core_clk = ~core_clk;
  nirm_regs u_nirm_regs (.core_clk, .resetn, .soft_reset, .bus, .unused_bus_echo_n(),
    .rdata, .ee_upper_load, .ee_lower_load, .ee_data, .uid_upper_locked(up_lk),
    .uid_lower_locked(lo_lk), .rom_req, .rom_map);
  nirm_rom_node u_nirm_rom_node (.core_clk, .rom_req);
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    bus <= {2'b10, a, d};
    @(posedge core_clk);
    bus <= '0;
  endtask
  // Read data stand only in the cycle after the strobe, so sample just past that edge.
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    bus <= {2'b01, a, 32'h0};
    @(posedge core_clk);
    bus <= '0;
    #1 chk({1'b0, rdata}, {1'b0, exp});
  endtask
  task automatic ee(input logic up, input logic [31:0] d);
    @(posedge core_clk);
    ee_upper_load <= up;
    ee_lower_load <= !up;
    ee_data <= d;
    @(posedge core_clk);
    ee_upper_load <= 1'b0;
    ee_lower_load <= 1'b0;
  endtask
  task automatic hw_reset();
    resetn <= 1'b0;
    repeat (5) @(posedge core_clk);
    resetn <= 1'b1;
  endtask
  task automatic t_caps();
    rd(8'h20, 32'h0000A002);
    @(posedge core_clk);
    #1 chk({1'b0, rdata}, 33'h0);
    rd(8'h30, 32'h0);
    wr(8'h20, 32'hFFFFFFFF);
    rd(8'h20, 32'h0000F0C2);
    wr(8'h20, 32'h00005040);
    @(posedge core_clk) soft_reset <= 1'b1;
    @(posedge core_clk) soft_reset <= 1'b0;
    rd(8'h20, 32'h00005042);
  endtask
  task automatic t_map();
    rd(8'h34, 32'h0);
    wr(8'h34, 32'hFFFFFFFF);
    rd(8'h34, 32'hFFFFFC00);
    wr(8'h34, 32'h12345678);
    u_nirm_rom_node.read_quad(48'hFFFFF0000400);
    #1 chk(rom_map, {1'b1, 32'h12345400});
    u_nirm_rom_node.read_quad(48'hFFFFF00007FF);
    #1 chk(rom_map, {1'b1, 32'h123457FF});
    u_nirm_rom_node.read_quad(48'hFFFFF0000800);
    #1 chk(rom_map, {1'b0, 32'h123457FF});
    u_nirm_rom_node.read_quad(48'hFFFFF00003FF);
    #1 chk(rom_map, {1'b0, 32'h123457FF});
  endtask
  // Each ID quadlet keeps its first load; later loads from either source bounce off.
  task automatic t_uid();
    rd(8'h24, 32'h0);
    ee(1'b1, 32'hAAAA5555);
    wr(8'h24, 32'h0);
    ee(1'b1, 32'h0);
    rd(8'h24, 32'hAAAA5555);
    wr(8'h28, 32'h13572468);
    ee(1'b0, 32'hFFFFFFFF);
    rd(8'h28, 32'h13572468);
    chk({31'h0, up_lk, lo_lk}, 33'h3);
    hw_reset();
    rd(8'h24, 32'h0);
    rd(8'h28, 32'h0);
    chk({31'h0, up_lk, lo_lk}, 33'h0);
  endtask
  task automatic report_and_stop();
    $display("comparisons=%0d mismatches=%0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    hw_reset();
    t_caps();
    t_map();
    t_uid();
    report_and_stop();
  end
  // The run needs about 60 cycles; this limit of 800 cycles is far beyond it.
  initial begin
    #20us;
    bad_count++;
    report_and_stop();
  end
endmodule // nirm_regs_tb
